// >>> src/sast_pkg.sv
// Constants shared by the status annunciation and self-test block.
// Assumes a 100 MHz system clock; all timing except the blink derives from a seconds tick.
package sast_pkg;
   // ***********************************************************
   // Timing
   // ***********************************************************
   localparam int unsigned CLK_HZ = 100000000; // System clock rate
   localparam int unsigned TICK_CYCLES = CLK_HZ; // Cycles per second
   localparam int unsigned ROTATE_S = 5; // Newest message hold time
   localparam int unsigned TEST_PERIOD_S = 5; // Fast test repetition
   localparam int unsigned FAIL_COUNT = 5; // Consecutive fails to log
   localparam int unsigned TEMP_PERIOD_S = 3600; // Temperature check
   localparam int unsigned FLASH_DEF_S = 4; // Default flash time
   localparam int unsigned BLINK_HALF = 50000000; // Half blink period
   // ***********************************************************
   // Thresholds and codes
   // ***********************************************************
   localparam logic [7:0] TEMP_LIMIT_C = 8'h50; // 80 degrees C
   localparam int unsigned NUM_LAMPS = 8; // Programmable lamps
   localparam int unsigned NUM_COND = 8; // Target condition slots
   localparam int unsigned NUM_OUT = 6; // Blockable output contacts
   // Lamp colour codes for lamps 5 to 8
   localparam logic [1:0] COL_OFF = 2'h0;
   localparam logic [1:0] COL_RED = 2'h1;
   localparam logic [1:0] COL_ORANGE = 2'h2;
   localparam logic [1:0] COL_GREEN = 2'h3;
   // Element function settings
   localparam logic [1:0] FN_TRIP = 2'h0;
   localparam logic [1:0] FN_ALARM = 2'h1;
   localparam logic [1:0] FN_LATCH = 2'h2;
   // Element state codes shown on the display
   localparam logic [1:0] ST_PICKUP = 2'h0;
   localparam logic [1:0] ST_OPER = 2'h1;
   localparam logic [1:0] ST_ALARM = 2'h2;
   // Event recorder codes
   localparam logic [3:0] EV_CLOCK = 4'h1;
   localparam logic [3:0] EV_TEMP = 4'h2;
   localparam logic [3:0] EV_UNIT = 4'h3;
   // Display source selection
   typedef enum logic [1:0] {
      SAST_DISP_MENU, SAST_DISP_TARGET, SAST_DISP_FLASH, SAST_DISP_ERR
   } sast_disp_e;
endpackage

// >>> src/sast_top.sv
// Status lamps, target message rotation, flash messages and self-test
// supervision. Keypad and condition inputs are synchronous to clk_sys_i;
// protection elements and the real-time clock sit outside.
`timescale 1ns/1ps
// Overview of operation
// - Plain alarm flashes lamp, clears with condition
// - Latched alarm holds alarm lamp steady on
// - Eight lamps, source, type, colour on 5-8
// - Every active condition gets a target message
// - Newest first, rotate others after 5 s
// - Scroll keys step previous or next message
// - Other key hides targets until idle timeout
// - Message shows element, state and phase
// - Self-test at power-up then background; minor/major
// - Minor: fault lamp, in service on, log
// - Major: drop output 7, block outputs 1-6
// - Major: service off, fault on, alarm flash
// - Five consecutive fails before logging, 25 s
// - Clock-not-set minor alert, checked every 5 s
// - Hourly check, minor alert above 80 C
// - Unit failure: latched major, code, 5 s
// - Flash message shown programmable time, default 4
module sast_top import sast_pkg::*; #(
   parameter int unsigned TICK_CYC = TICK_CYCLES, // Cycles per second
   parameter int unsigned BLINK_CYC = BLINK_HALF // Half blink cycles
) (
   input wire logic clk_sys_i, // System clock
   input wire logic arst_n_i, // Asynchronous reset, active low
   input wire logic relay_ready_i, // Relay programmed and ready
   // Target conditions, one slot per element
   input wire logic [NUM_COND-1:0] cond_act_i, // Condition active
   input wire logic [NUM_COND*2-1:0] cond_fn_i, // Function per slot
   input wire logic [NUM_COND*2-1:0] cond_state_i, // State per slot
   input wire logic [NUM_COND*3-1:0] cond_phase_i, // Phases A,B,C
   input wire logic [NUM_COND-1:0] cond_alarm_i, // Alarm condition
   // Keypad
   input wire logic key_up_i, // Scroll up pulse
   input wire logic key_down_i, // Scroll down pulse
   input wire logic key_reset_i, // Reset key pulse
   input wire logic key_other_i, // Any other key pulse
   input wire logic flash_req_i, // Key wants a flash message
   input wire logic [3:0] flash_code_i, // Flash message code
   input wire logic [7:0] flash_time_s_i, // Flash time, seconds
   input wire logic [7:0] idle_time_s_i, // Display idle delay
   // Programmable lamp settings
   input wire logic [NUM_LAMPS*4-1:0] lamp_src_i, // Source index
   input wire logic [NUM_LAMPS-1:0] lamp_latch_i, // Type: latched
   input wire logic [7:0] lamp_col_i, // Colours, lamps 5 to 8
   input wire logic [15:0] lamp_sig_i, // Selectable sources
   // Self-test inputs
   input wire logic rtc_default_i, // Clock equals default
   input wire logic [7:0] temp_c_i, // Ambient temperature
   input wire logic hw_fail_i, // Hardware check failing
   input wire logic [15:0] hw_code_i, // Hardware failure code
   input wire logic [NUM_OUT:1] out_req_i, // Requested contacts 1-6
   // Outputs
   output logic in_service_o, // In-service lamp
   output logic fault_lamp_o, // Fault lamp
   output logic alarm_lamp_o, // Alarm lamp
   output logic [NUM_LAMPS-1:0] lamp_on_o, // Programmable lamps
   output logic [7:0] lamp_color_o, // Colours of lamps 5 to 8
   output logic [NUM_OUT:1] out_cmd_o, // Contacts 1 to 6
   output logic crit_fail_o, // Output 7, energised when healthy
   output logic [1:0] disp_sel_o, // Display source
   output logic [2:0] msg_idx_o, // Shown condition slot
   output logic [1:0] msg_fn_o, // Shown element function
   output logic [1:0] msg_state_o, // Shown element state
   output logic [2:0] msg_phase_o, // Shown phases
   output logic [3:0] flash_code_o, // Shown flash code
   output logic minor_o, // Minor self-test problem
   output logic major_o, // Major self-test problem
   output logic [15:0] err_code_o, // Shown failure code
   output logic log_stb_o, // Event recorder strobe
   output logic [3:0] log_code_o // Event recorder code
);
   // ***********************************************************
   // Reset release and seconds tick
   // ***********************************************************
   logic rst_s1_q, rst_n_q; // Reset synchroniser
   always_ff @(posedge clk_sys_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         rst_s1_q <= 1'b0;
         rst_n_q <= 1'b0;
      end else begin
         rst_s1_q <= 1'b1;
         rst_n_q <= rst_s1_q;
      end
   end
   logic [31:0] tick_cnt_q; // Cycle count within a second
   logic [31:0] blink_cnt_q; // Blink half-period count
   logic blink_q; // Shared blink phase
   wire tick_w = (tick_cnt_q == 32'(TICK_CYC - 1));
   wire blink_end_w = (blink_cnt_q == 32'(BLINK_CYC - 1));
   // Seconds tick and blink phase run from separate free-running counters
   always_ff @(posedge clk_sys_i or negedge rst_n_q) begin
      if (!rst_n_q) begin
         tick_cnt_q <= 32'h0;
         blink_cnt_q <= 32'h0;
         blink_q <= 1'b0;
      end else begin
         tick_cnt_q <= tick_w ? 32'h0 : tick_cnt_q + 32'h1;
         blink_cnt_q <= blink_end_w ? 32'h0 : blink_cnt_q + 32'h1;
         if (blink_end_w) begin
            blink_q <= ~blink_q;
         end
      end
   end
   // ***********************************************************
   // Self-test scheduler
   // ***********************************************************
   logic [2:0] fast_sec_q; // Seconds within 5 s period
   logic [11:0] hour_sec_q; // Seconds within the hour
   logic init_q; // Power-up pass still pending
   logic [2:0] clk_fail_q, hw_fail_q; // Consecutive fail counts
   logic clk_alert_q, temp_alert_q, unit_fail_q;
   logic [15:0] code_q; // Latched failure code
   wire fast_run_w = init_q | (tick_w && fast_sec_q == 3'(TEST_PERIOD_S - 1));
   wire hour_run_w = init_q | (tick_w && hour_sec_q == 12'(TEMP_PERIOD_S - 1));
   wire clk_hit_w = fast_run_w && rtc_default_i &&
                    clk_fail_q == 3'(FAIL_COUNT - 1);
   wire hw_hit_w = fast_run_w && hw_fail_i &&
                   hw_fail_q == 3'(FAIL_COUNT - 1);
   wire temp_hot_w = temp_c_i > TEMP_LIMIT_C;
   // Runs once at release and then forever in background
   always_ff @(posedge clk_sys_i or negedge rst_n_q) begin
      if (!rst_n_q) begin
         init_q <= 1'b1;
         fast_sec_q <= 3'h0;
         hour_sec_q <= 12'h0;
      end else begin
         init_q <= 1'b0;
         if (tick_w) begin
            fast_sec_q <= (fast_sec_q == 3'(TEST_PERIOD_S - 1)) ? 3'h0 :
                          fast_sec_q + 3'h1;
            hour_sec_q <= (hour_sec_q == 12'(TEMP_PERIOD_S - 1)) ? 12'h0 :
                          hour_sec_q + 12'h1;
         end
      end
   end
   // Counters saturate at the threshold; one clean pass clears
   always_ff @(posedge clk_sys_i or negedge rst_n_q) begin
      if (!rst_n_q) begin
         clk_fail_q <= 3'h0;
         hw_fail_q <= 3'h0;
         clk_alert_q <= 1'b0;
         temp_alert_q <= 1'b0;
         unit_fail_q <= 1'b0;
         code_q <= 16'h0;
      end else begin
         if (fast_run_w) begin
            clk_fail_q <= !rtc_default_i ? 3'h0 : (clk_hit_w ?
                          clk_fail_q : clk_fail_q + 3'h1);
            hw_fail_q <= !hw_fail_i ? 3'h0 : (hw_hit_w ?
                         hw_fail_q : hw_fail_q + 3'h1);
            // Not latched: follows each check result
            clk_alert_q <= clk_hit_w;
         end
         if (hour_run_w) begin
            temp_alert_q <= temp_hot_w;
         end
         // Latched until power cycle; reset key cannot clear it
         if (hw_hit_w && !unit_fail_q) begin
            unit_fail_q <= 1'b1;
            code_q <= hw_code_i;
         end
      end
   end
   // Log only on entry into a failed state
   logic clk_alert_d1_q, temp_d1_q, unit_d1_q;
   always_ff @(posedge clk_sys_i or negedge rst_n_q) begin
      if (!rst_n_q) begin
         clk_alert_d1_q <= 1'b0;
         temp_d1_q <= 1'b0;
         unit_d1_q <= 1'b0;
      end else begin
         clk_alert_d1_q <= clk_alert_q;
         temp_d1_q <= temp_alert_q;
         unit_d1_q <= unit_fail_q;
      end
   end
   wire log_unit_w = unit_fail_q & ~unit_d1_q;
   wire log_clk_w = clk_alert_q & ~clk_alert_d1_q;
   wire log_temp_w = temp_alert_q & ~temp_d1_q;
   assign log_stb_o = log_unit_w | log_clk_w | log_temp_w;
   assign log_code_o = log_unit_w ? EV_UNIT : (log_clk_w ? EV_CLOCK :
                       (log_temp_w ? EV_TEMP : 4'h0));
   assign minor_o = clk_alert_q | temp_alert_q;
   assign major_o = unit_fail_q;
   assign err_code_o = code_q;
   // ***********************************************************
   // Status lamps and contacts
   // ***********************************************************
   logic [NUM_COND-1:0] latch_q; // Latched alarm memory
   logic [NUM_COND-1:0] plain_al_w, latch_set_w;
   genvar gi;
   for (gi = 0; gi < NUM_COND; gi++) begin : g_alarm
      assign plain_al_w[gi] = cond_alarm_i[gi] &&
                              cond_fn_i[gi*2 +: 2] == FN_ALARM;
      assign latch_set_w[gi] = cond_alarm_i[gi] &&
                               cond_fn_i[gi*2 +: 2] == FN_LATCH;
   end
   // Latched alarms drop only on reset key once inactive
   always_ff @(posedge clk_sys_i or negedge rst_n_q) begin
      if (!rst_n_q) begin
         latch_q <= '0;
      end else begin
         latch_q <= latch_set_w |
                    (key_reset_i ? '0 : latch_q);
      end
   end
   assign alarm_lamp_o = (|latch_q) ? 1'b1 :
                         ((|plain_al_w) | unit_fail_q) & blink_q;
   assign in_service_o = relay_ready_i & ~unit_fail_q;
   assign fault_lamp_o = ~relay_ready_i | unit_fail_q | minor_o;
   assign crit_fail_o = ~unit_fail_q;
   assign out_cmd_o = unit_fail_q ? '0 : out_req_i;
   // Programmable lamps: self-resetting or latched per lamp
   logic [NUM_LAMPS-1:0] lamp_q;
   logic [NUM_LAMPS-1:0] lamp_src_w;
   for (gi = 0; gi < NUM_LAMPS; gi++) begin : g_lamp
      assign lamp_src_w[gi] = lamp_sig_i[lamp_src_i[gi*4 +: 4]];
   end
   always_ff @(posedge clk_sys_i or negedge rst_n_q) begin
      if (!rst_n_q) begin
         lamp_q <= '0;
      end else begin
         lamp_q <= lamp_src_w | (lamp_q & lamp_latch_i &
                   {NUM_LAMPS{~key_reset_i}});
      end
   end
   assign lamp_on_o = lamp_q;
   assign lamp_color_o = lamp_col_i;
   // ***********************************************************
   // Target message rotation and display selection
   // ***********************************************************
   logic [2:0] idx_q; // Shown slot
   logic [2:0] hold_q; // Seconds shown before rotating
   logic [7:0] idle_q; // Idle seconds since an other-key press
   logic hidden_q; // Targets hidden by keypad use
   logic [7:0] flash_q; // Flash seconds remaining
   logic [3:0] fcode_q;
   logic [NUM_COND-1:0] act_prev_q;
   wire any_act_w = |cond_act_i;
   wire [NUM_COND-1:0] new_w = cond_act_i & ~act_prev_q;
   logic [2:0] newest_w; // Highest newly active slot
   always_comb begin
      newest_w = 3'h0;
      for (int i = 0; i < NUM_COND; i++) begin
         if (new_w[i]) begin
            newest_w = 3'(i);
         end
      end
   end
   // Next and previous active slot, wrapping round
   logic [2:0] next_w, prev_w;
   always_comb begin
      next_w = idx_q;
      prev_w = idx_q;
      for (int k = NUM_COND - 1; k >= 1; k--) begin
         if (cond_act_i[3'(idx_q + 3'(k))]) begin
            next_w = 3'(idx_q + 3'(k));
         end
         if (cond_act_i[3'(idx_q - 3'(k))]) begin
            prev_w = 3'(idx_q - 3'(k));
         end
      end
   end
   always_ff @(posedge clk_sys_i or negedge rst_n_q) begin
      if (!rst_n_q) begin
         act_prev_q <= '0;
         idx_q <= 3'h0;
         hold_q <= 3'h0;
      end else begin
         act_prev_q <= cond_act_i;
         if (|new_w) begin
            idx_q <= newest_w;
            hold_q <= 3'h0;
         end else if (key_up_i) begin
            idx_q <= prev_w;
            hold_q <= 3'h0;
         end else if (key_down_i) begin
            idx_q <= next_w;
            hold_q <= 3'h0;
         end else if (tick_w) begin
            if (hold_q == 3'(ROTATE_S - 1)) begin
               idx_q <= next_w;
               hold_q <= 3'h0;
            end else begin
               hold_q <= hold_q + 3'h1;
            end
         end
      end
   end
   // Other-key presses hide targets until the idle delay expires
   always_ff @(posedge clk_sys_i or negedge rst_n_q) begin
      if (!rst_n_q) begin
         hidden_q <= 1'b0;
         idle_q <= 8'h0;
      end else begin
         if (key_other_i) begin
            hidden_q <= 1'b1;
            idle_q <= 8'h0;
         end else if (tick_w && hidden_q) begin
            if (idle_q + 8'h1 >= idle_time_s_i) begin
               hidden_q <= 1'b0;
            end
            idle_q <= idle_q + 8'h1;
         end
      end
   end
   // Flash time counts whole ticks; zero falls back to default
   always_ff @(posedge clk_sys_i or negedge rst_n_q) begin
      if (!rst_n_q) begin
         flash_q <= 8'h0;
         fcode_q <= 4'h0;
      end else begin
         if (flash_req_i) begin
            flash_q <= (flash_time_s_i == 8'h0) ? 8'(FLASH_DEF_S) :
                       flash_time_s_i;
            fcode_q <= flash_code_i;
         end else if (tick_w && flash_q != 8'h0) begin
            flash_q <= flash_q - 8'h1;
         end
      end
   end
   wire show_tgt_w = any_act_w & ~hidden_q;
   // Minor problems show their error too, below flash messages
   assign disp_sel_o = (flash_q != 8'h0) ? SAST_DISP_FLASH :
                       ((unit_fail_q | minor_o) ? SAST_DISP_ERR :
                       (show_tgt_w ? SAST_DISP_TARGET : SAST_DISP_MENU));
   assign msg_idx_o = idx_q;
   assign msg_fn_o = cond_fn_i[idx_q*2 +: 2];
   assign msg_state_o = cond_state_i[idx_q*2 +: 2];
   assign msg_phase_o = cond_phase_i[idx_q*3 +: 3];
   assign flash_code_o = fcode_q;
   // ***********************************************************
   // Checks
   // ***********************************************************
   sequence s_unit_set;
      $rose(unit_fail_q);
   endsequence
   AST_MAJOR_BLOCK: assert property (@(posedge clk_sys_i) disable iff (!rst_n_q)
      unit_fail_q |-> (out_cmd_o == '0 && !crit_fail_o))
      else $error("outputs not blocked on major failure");
   AST_MAJOR_LAMPS: assert property (@(posedge clk_sys_i) disable iff (!rst_n_q)
      unit_fail_q |-> (!in_service_o && fault_lamp_o))
      else $error("status lamps wrong on major failure");
   AST_MAJOR_LOG: assert property (@(posedge clk_sys_i) disable iff (!rst_n_q)
      s_unit_set |-> (log_stb_o && log_code_o == EV_UNIT))
      else $error("major failure not logged");
   AST_UNIT_LATCH: assert property (@(posedge clk_sys_i) disable iff (!rst_n_q)
      unit_fail_q |=> unit_fail_q)
      else $error("unit failure did not stay latched");
   AST_FAIL_COUNT: assert property (@(posedge clk_sys_i) disable iff (!rst_n_q)
      $rose(unit_fail_q) |-> $past(hw_fail_q) == 3'h4)
      else $error("unit failure before five failing checks");
   AST_MINOR_LAMPS: assert property (@(posedge clk_sys_i) disable iff (!rst_n_q)
      (minor_o && !unit_fail_q && relay_ready_i) |-> (fault_lamp_o && in_service_o))
      else $error("minor problem lamps wrong");
   AST_TEMP: assert property (@(posedge clk_sys_i) disable iff (!rst_n_q)
      (hour_run_w && temp_c_i > 8'h50) |=> temp_alert_q)
      else $error("hot ambient not flagged");
   AST_LATCH_ALARM: assert property (@(posedge clk_sys_i) disable iff (!rst_n_q)
      (|latch_q) |-> alarm_lamp_o)
      else $error("latched alarm lamp not steady");
   AST_FLASH_SHOW: assert property (@(posedge clk_sys_i) disable iff (!rst_n_q)
      flash_req_i |=> disp_sel_o == SAST_DISP_FLASH)
      else $error("flash message not shown");
   AST_HIDE: assert property (@(posedge clk_sys_i) disable iff (!rst_n_q)
      (key_other_i && flash_q == 8'h0 && !unit_fail_q) |=>
      (disp_sel_o != SAST_DISP_TARGET || flash_q != 8'h0))
      else $error("targets not hidden after key");
endmodule

// >>> tb/sast_panel_model.sv
// Keypad model for the annunciation block: one-cycle key pulses.
// Assumes the bench calls press() from its main sequence only.
`timescale 1ns/1ps
module sast_panel_model (
   input wire logic clk_sys_i, // System clock
   output logic key_up_o, // Scroll up pulse
   output logic key_down_o, // Scroll down pulse
   output logic key_reset_o, // Reset key pulse
   output logic key_other_o // Any other key pulse
);
   // ***********************************************************
   // Keys
   // ***********************************************************
   // All keys released at time zero
   initial begin
      key_up_o = 1'b0;
      key_down_o = 1'b0;
      key_reset_o = 1'b0;
      key_other_o = 1'b0;
   end
   // Code 0 up, 1 down, 2 reset, 3 other; the key is held one cycle
   // and released on the next edge, so two presses never merge
   task automatic press(input logic [1:0] k);
      @(posedge clk_sys_i);
      key_up_o <= (k == 2'h0);
      key_down_o <= (k == 2'h1);
      key_reset_o <= (k == 2'h2);
      key_other_o <= (k == 2'h3);
      @(posedge clk_sys_i);
      {key_up_o, key_down_o, key_reset_o, key_other_o} <= 4'h0;
   endtask
endmodule

// >>> tb/tb.sv
// Self-checking bench for the annunciation and self-test block.
// Assumes short timing: 10 cycles a second, blink half period 3.
`timescale 1ns/1ps
module tb import sast_pkg::*;;
   logic clk_sys_i, arst_n_i, ready, rtc, hwf, frq;
   logic [7:0] act, alm, latch, col, temp, ftime, idle;
   logic [15:0] fn, st, sig, code;
   logic [23:0] ph;
   logic [31:0] src;
   logic [3:0] fcode, last_log;
   logic [6:1] oreq;
   logic ku, kd, kr, ko, insv, flt, alam, crit, minr, majr, lstb;
   logic [7:0] lon, lcol;
   logic [6:1] ocmd;
   logic [1:0] dsel, mfn, mst;
   logic [2:0] midx, mph;
   logic [3:0] fco, lcode;
   logic [15:0] ecode;
   int mismatches, comparisons, n, hi, lo;
   sast_panel_model panel_u (.clk_sys_i(clk_sys_i), .key_up_o(ku),
      .key_down_o(kd), .key_reset_o(kr), .key_other_o(ko));
   sast_top #(.TICK_CYC(10), .BLINK_CYC(3)) dut_u (
      .clk_sys_i(clk_sys_i), .arst_n_i(arst_n_i), .relay_ready_i(ready),
      .cond_act_i(act), .cond_fn_i(fn), .cond_state_i(st),
      .cond_phase_i(ph), .cond_alarm_i(alm), .key_up_i(ku),
      .key_down_i(kd), .key_reset_i(kr), .key_other_i(ko),
      .flash_req_i(frq), .flash_code_i(fcode), .flash_time_s_i(ftime),
      .idle_time_s_i(idle), .lamp_src_i(src), .lamp_latch_i(latch),
      .lamp_col_i(col), .lamp_sig_i(sig), .rtc_default_i(rtc),
      .temp_c_i(temp), .hw_fail_i(hwf), .hw_code_i(code),
      .out_req_i(oreq), .in_service_o(insv), .fault_lamp_o(flt),
      .alarm_lamp_o(alam), .lamp_on_o(lon), .lamp_color_o(lcol),
      .out_cmd_o(ocmd), .crit_fail_o(crit), .disp_sel_o(dsel),
      .msg_idx_o(midx), .msg_fn_o(mfn), .msg_state_o(mst),
      .msg_phase_o(mph), .flash_code_o(fco), .minor_o(minr),
      .major_o(majr), .err_code_o(ecode), .log_stb_o(lstb),
      .log_code_o(lcode));
   // ***********************************************************
   // Clock, log capture and helpers
   // ***********************************************************
   initial begin
      clk_sys_i = 1'b0;
      forever #5 clk_sys_i = ~clk_sys_i;
   end
   // Keep the last recorder code; the strobe is only one cycle wide
   always @(posedge clk_sys_i) if (lstb === 1'b1) last_log <= lcode;
   task automatic cyc(input int k);
      repeat (k) @(posedge clk_sys_i);
      #1;
   endtask
   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      comparisons++;
      if (seen !== exp) begin
         mismatches++;
         $display("Error at %0t: saw %0h expected %0h", $time, seen, exp);
      end
   endtask
   // Wait for minor (sel 0) or major (sel 1) to reach v, bounded
   task automatic wflag(input bit sel, input logic v, input int lim);
      n = 0;
      while (((sel ? majr : minr) !== v) && n < lim) begin
         cyc(1);
         n++;
      end
   endtask
   // Count high and low samples of the alarm lamp over eight cycles
   task automatic blink();
      hi = 0;
      lo = 0;
      repeat (8) begin
         cyc(1);
         if (alam === 1'b1) hi++;
         if (alam === 1'b0) lo++;
      end
   endtask
   task automatic end_sim();
      $display("comparisons %0d mismatches %0d", comparisons, mismatches);
      if (mismatches == 0 && comparisons > 0) $display("RESULT: PASS");
      else $display("RESULT: FAIL");
      $finish;
   endtask
   // ***********************************************************
   // Scenarios
   // ***********************************************************
   task automatic t_lamps();
      @(posedge clk_sys_i);
      src[3:0] <= 4'h3;
      sig <= 16'h0008;
      col <= 8'hE4;
      latch <= 8'h01;
      ready <= 1'b0;
      cyc(3);
      chk(lon[0], 1'b1);
      chk(lcol, 8'hE4);
      chk({insv, flt}, 2'h1);
      @(posedge clk_sys_i);
      sig <= 16'h0000;
      ready <= 1'b1;
      cyc(3);
      chk(lon[0], 1'b1);
      chk({insv, flt}, 2'h2);
      panel_u.press(2'h2);
      cyc(2);
      chk(lon[0], 1'b0);
      @(posedge clk_sys_i);
      latch <= 8'h00;
      $display("lamps done");
   endtask
   task automatic t_alarm();
      @(posedge clk_sys_i);
      fn[1:0] <= FN_ALARM;
      alm <= 8'h01;
      blink();
      chk(hi > 0 && lo > 0, 1'b1);
      @(posedge clk_sys_i);
      alm <= 8'h00;
      cyc(3);
      chk(alam, 1'b0);
      @(posedge clk_sys_i);
      fn[3:2] <= FN_LATCH;
      alm <= 8'h02;
      cyc(2);
      blink();
      chk(hi, 8);
      @(posedge clk_sys_i);
      alm <= 8'h00;
      panel_u.press(2'h2);
      cyc(3);
      chk(alam, 1'b0);
      $display("alarm done");
   endtask
   task automatic t_target();
      @(posedge clk_sys_i);
      act <= 8'h04;
      st[5:4] <= ST_OPER;
      ph[8:6] <= 3'h1;
      cyc(3);
      @(posedge clk_sys_i);
      act <= 8'h24;
      cyc(2);
      chk(dsel, SAST_DISP_TARGET);
      chk(midx, 3'h5);
      n = 0;
      while (midx === 3'h5 && n < 100) begin
         cyc(1);
         n++;
      end
      // Five whole ticks after the new slot; the first tick may be near
      chk(n >= 40 && n <= 49, 1'b1);
      chk({midx, mfn, mst, mph}, {3'h2, FN_TRIP, ST_OPER, 3'h1});
      panel_u.press(2'h0);
      cyc(1);
      chk(midx, 3'h5);
      panel_u.press(2'h1);
      cyc(1);
      chk(midx, 3'h2);
      panel_u.press(2'h3);
      cyc(1);
      chk(dsel, SAST_DISP_MENU);
      cyc(15);
      chk(dsel, SAST_DISP_MENU);
      cyc(20);
      chk(dsel, SAST_DISP_TARGET);
      @(posedge clk_sys_i);
      act <= 8'h00;
      cyc(3);
      chk(dsel, SAST_DISP_MENU);
      $display("target done");
   endtask
   task automatic t_flash(input logic [7:0] t, input int len);
      @(posedge clk_sys_i);
      frq <= 1'b1;
      fcode <= 4'hA;
      ftime <= t;
      @(posedge clk_sys_i);
      frq <= 1'b0;
      cyc(1);
      chk({dsel, fco}, {SAST_DISP_FLASH, 4'hA});
      // Flash ends between len-9 and len cycles after capture
      cyc(len - 11);
      chk(dsel, SAST_DISP_FLASH);
      cyc(12);
      chk(dsel, SAST_DISP_MENU);
      $display("flash done");
   endtask
   task automatic t_minor();
      @(posedge clk_sys_i);
      rtc <= 1'b1;
      wflag(1'b0, 1'b1, 400);
      chk(n >= 190 && n <= 260, 1'b1);
      chk({insv, flt, dsel}, {2'h3, SAST_DISP_ERR});
      cyc(2);
      chk(last_log, EV_CLOCK);
      @(posedge clk_sys_i);
      rtc <= 1'b0;
      cyc(60);
      chk(minr, 1'b0);
      @(posedge clk_sys_i);
      temp <= 8'h51;
      wflag(1'b0, 1'b1, 36100);
      chk(minr, 1'b1);
      cyc(2);
      chk(last_log, EV_TEMP);
      @(posedge clk_sys_i);
      temp <= TEMP_LIMIT_C;
      wflag(1'b0, 1'b0, 36100);
      chk(minr, 1'b0);
      $display("minor done");
   endtask
   task automatic t_major();
      @(posedge clk_sys_i);
      oreq <= 6'h3F;
      hwf <= 1'b1;
      code <= 16'h1234;
      cyc(2);
      chk({ocmd, crit}, 7'h7F);
      wflag(1'b1, 1'b1, 400);
      chk(n >= 190 && n <= 260, 1'b1);
      chk({ocmd, crit}, 7'h00);
      chk({insv, flt}, 2'h1);
      chk({dsel, ecode}, {SAST_DISP_ERR, 16'h1234});
      blink();
      chk(hi > 0 && lo > 0, 1'b1);
      chk(last_log, EV_UNIT);
      @(posedge clk_sys_i);
      hwf <= 1'b0;
      panel_u.press(2'h2);
      cyc(60);
      chk(majr, 1'b1);
      $display("major done");
   endtask
   // ***********************************************************
   // Main sequence and watchdog
   // ***********************************************************
   initial begin
      {arst_n_i, rtc, hwf, frq, alm, latch, col, temp} = '0;
      {act, fn, st, ph, sig, src, code, oreq, fcode} = '0;
      {mismatches, comparisons} = '0;
      {ready, idle, ftime, last_log} = {1'b1, 8'h03, 8'h00, 4'h0};
      cyc(3);
      @(posedge clk_sys_i);
      arst_n_i <= 1'b1;
      cyc(5);
      t_lamps();
      t_alarm();
      t_target();
      t_flash(8'h00, 40);
      t_flash(8'h02, 20);
      t_minor();
      t_major();
      end_sim();
   end
   // Whole run is about 72400 cycles; stop a hang well past that
   initial begin
      repeat (95000) @(posedge clk_sys_i);
      mismatches++;
      end_sim();
   end
endmodule
